// ===== logic/i2csad_defs.vh
`ifndef I2CSAD_DEFS_VH
`define I2CSAD_DEFS_VH

// Register offsets (byte addresses)
`define I2CSAD_OFF_BYTE_BUFFER 8'h0C
`define I2CSAD_OFF_SLAVE_ID_PRIMARY 8'h10
`define I2CSAD_OFF_COND_CODE 8'h14
`define I2CSAD_OFF_SLAVE_ID_SECOND 8'h20
`define I2CSAD_OFF_SLAVE_ID_THIRD 8'h24
`define I2CSAD_OFF_HIT_FLAGS 8'h28
`define I2CSAD_OFF_CONTROL 8'h30
`define I2CSAD_OFF_IRQ_STATUS 8'h34
`define I2CSAD_OFF_IRQ_MASK 8'h38

// Control register fields
`define I2CSAD_CTL_ACK_ASSERT 0
`define I2CSAD_CTL_IRQ_FLAG 1
`define I2CSAD_CTL_MASTER 2

// Slave identifier fields
`define I2CSAD_GC_BIT 0

// Interrupt status fields
`define I2CSAD_IRQ_COND 0
`define I2CSAD_IRQ_HIT 1
`define I2CSAD_IRQ_GCALL 2
`define I2CSAD_IRQ_W 3

// Condition code values (idle is the reset value)
`define I2CSAD_COND_IDLE 8'hF8
`define I2CSAD_COND_ERROR 8'h00

`endif

// ===== logic/i2csad_id_cmp.v
`timescale 1ns/100ps
// Compares a received 7-bit device identifier with one programmed slot
module i2csad_id_cmp #(
	parameter ID_W = 7
) (
	// Programmed and received identifiers
	input wire [ID_W-1:0] slot_id_in,
	input wire [ID_W-1:0] rx_id_in,
	// Result
	output wire hit_out
);
	// Equality check, all-zero slot never matches
	assign hit_out = (slot_id_in == rx_id_in) && (slot_id_in != {ID_W{1'b0}});
endmodule

// ===== logic/i2csad_regs.v
// Summary of operation
// RULE1 - Data byte low eight bits: next byte to send, or last byte received.
// RULE2 - Condition code idle value keeps the interrupt flag cleared.
// RULE3 - Any other defined condition code sets the flag and requests interrupt.
// RULE4 - Condition code is read-only and resets to the idle code.
// RULE5 - Slave compares first address byte with primary identifier; acks when enabled.
// RULE6 - Software must not program primary identifier as all zeros.
// RULE7 - General call accepted only with ack enabled; otherwise ignored.
// RULE8 - Second and third identifiers exist; identifiers ignored in master mode.
// RULE9 - Hit flags bits 0..2 follow matches with primary, second, third identifiers.
// RULE10 - Hit flags clear on reset and on START or STOP.
// RULE11 - Software clears interrupt flag by writing zero; bus is held meanwhile.
// RULE12 - Ack enable one drives ACK, zero drives NACK.
// RULE13 - Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`include "i2csad_defs.vh"
module i2csad_regs #(
	parameter ID_W = 7
) (
	// Clock and reset
	input wire CLK_IN,
	input wire RESET_IN,
	// Register port
	input wire [7:0] REG_ADDR_IN,
	input wire [31:0] REG_WDATA_IN,
	input wire REG_WR_IN,
	input wire REG_RD_IN,
	output reg [31:0] REG_RDATA_OUT,
	// Bus engine side
	input wire ENG_COND_VALID_IN,
	input wire [7:0] ENG_COND_CODE_IN,
	input wire ENG_RX_BYTE_VALID_IN,
	input wire [7:0] ENG_RX_BYTE_IN,
	input wire ENG_ADDR_VALID_IN,
	input wire [7:0] ENG_ADDR_BYTE_IN,
	input wire ENG_START_STOP_IN,
	output wire [7:0] ENG_TX_BYTE_OUT,
	output wire ENG_ACK_ASSERT_OUT,
	output wire ENG_ACK_BIT_OUT,
	output wire ENG_ADDRESSED_OUT,
	output wire ENG_GCALL_OUT,
	output wire ENG_HOLD_SCL_OUT,
	output wire ENG_MASTER_OUT,
	// Interrupt
	output wire IRQ_OUT
);
	reg [7:0] byte_buffer_q;
	reg [7:0] slave_id_primary_q;
	reg [ID_W-1:0] slave_id_second_q;
	reg [ID_W-1:0] slave_id_third_q;
	reg [7:0] cond_code_q;
	reg [2:0] hit_q;
	reg [2:0] hit_d;
	reg ack_assert_q;
	reg irq_flag_q;
	reg irq_flag_d;
	reg master_q;
	reg addressed_q;
	reg gcall_q;
	reg [`I2CSAD_IRQ_W-1:0] irq_status_q;
	reg [`I2CSAD_IRQ_W-1:0] irq_status_d;
	reg [`I2CSAD_IRQ_W-1:0] irq_mask_q;
	wire [2:0] slot_hit;
	wire [ID_W-1:0] rx_id;
	wire is_gcall;
	wire wr_ctl;
	wire cond_active;

	assign rx_id = ENG_ADDR_BYTE_IN[7:1];
	assign is_gcall = (rx_id == {ID_W{1'b0}});
	assign wr_ctl = REG_WR_IN && (REG_ADDR_IN == `I2CSAD_OFF_CONTROL);
	assign cond_active = ENG_COND_VALID_IN && (ENG_COND_CODE_IN != `I2CSAD_COND_IDLE);

	// Three identifier comparators
	i2csad_id_cmp #(.ID_W(ID_W)) u_cmp_primary (
		.slot_id_in(slave_id_primary_q[7:1]),
		.rx_id_in(rx_id),
		.hit_out(slot_hit[0])
	);
	i2csad_id_cmp #(.ID_W(ID_W)) u_cmp_second (
		.slot_id_in(slave_id_second_q),
		.rx_id_in(rx_id),
		.hit_out(slot_hit[1])
	);
	i2csad_id_cmp #(.ID_W(ID_W)) u_cmp_third (
		.slot_id_in(slave_id_third_q),
		.rx_id_in(rx_id),
		.hit_out(slot_hit[2])
	);

	// Hit flag next value
	always @* begin
		hit_d = hit_q;
		if (ENG_START_STOP_IN) begin
			hit_d = 3'h0; // [RULE10]
		end else if (ENG_ADDR_VALID_IN && !master_q) begin
			hit_d = slot_hit; // [RULE9] [RULE8]
		end
	end

	// Interrupt flag next value: hardware set wins over software clear
	always @* begin
		irq_flag_d = irq_flag_q;
		if (wr_ctl && !REG_WDATA_IN[`I2CSAD_CTL_IRQ_FLAG]) begin
			irq_flag_d = 1'b0; // [RULE11]
		end
		if (ENG_COND_VALID_IN) begin
			if (ENG_COND_CODE_IN == `I2CSAD_COND_IDLE) begin
				irq_flag_d = 1'b0; // [RULE2]
			end else begin
				irq_flag_d = 1'b1; // [RULE3]
			end
		end
	end

	// Sticky interrupt status: write one to clear, events win
	always @* begin
		irq_status_d = irq_status_q;
		if (REG_WR_IN && (REG_ADDR_IN == `I2CSAD_OFF_IRQ_STATUS)) begin
			irq_status_d = irq_status_q & ~REG_WDATA_IN[`I2CSAD_IRQ_W-1:0];
		end
		if (cond_active) begin
			irq_status_d[`I2CSAD_IRQ_COND] = 1'b1; // [RULE3]
		end
		if (ENG_ADDR_VALID_IN && !master_q && (|slot_hit)) begin
			irq_status_d[`I2CSAD_IRQ_HIT] = 1'b1;
		end
		if (ENG_ADDR_VALID_IN && !master_q && is_gcall && slave_id_primary_q[`I2CSAD_GC_BIT] && ack_assert_q) begin
			irq_status_d[`I2CSAD_IRQ_GCALL] = 1'b1;
		end
	end

	// Software-written registers
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			slave_id_primary_q <= 8'h00;
			slave_id_second_q <= {ID_W{1'b0}};
			slave_id_third_q <= {ID_W{1'b0}};
			ack_assert_q <= 1'b0;
			master_q <= 1'b0;
			irq_mask_q <= {`I2CSAD_IRQ_W{1'b0}};
		end else if (REG_WR_IN) begin
			case (REG_ADDR_IN)
				`I2CSAD_OFF_SLAVE_ID_PRIMARY: begin
					slave_id_primary_q <= REG_WDATA_IN[7:0];
				end
				`I2CSAD_OFF_SLAVE_ID_SECOND: begin
					slave_id_second_q <= REG_WDATA_IN[7:1]; // [RULE8] [RULE13]
				end
				`I2CSAD_OFF_SLAVE_ID_THIRD: begin
					slave_id_third_q <= REG_WDATA_IN[7:1]; // [RULE8] [RULE13]
				end
				`I2CSAD_OFF_CONTROL: begin
					ack_assert_q <= REG_WDATA_IN[`I2CSAD_CTL_ACK_ASSERT];
					master_q <= REG_WDATA_IN[`I2CSAD_CTL_MASTER];
				end
				`I2CSAD_OFF_IRQ_MASK: begin
					irq_mask_q <= REG_WDATA_IN[`I2CSAD_IRQ_W-1:0];
				end
				default: begin
					irq_mask_q <= irq_mask_q;
				end
			endcase
		end
	end

	// Data byte: software write or received byte, reception wins
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			byte_buffer_q <= 8'h00;
		end else if (ENG_RX_BYTE_VALID_IN) begin
			byte_buffer_q <= ENG_RX_BYTE_IN; // [RULE1]
		end else if (REG_WR_IN && (REG_ADDR_IN == `I2CSAD_OFF_BYTE_BUFFER)) begin
			byte_buffer_q <= REG_WDATA_IN[7:0]; // [RULE1]
		end
	end

	// Hardware-owned state
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			cond_code_q <= `I2CSAD_COND_IDLE; // [RULE4]
			hit_q <= 3'h0; // [RULE10]
			irq_flag_q <= 1'b0;
			irq_status_q <= {`I2CSAD_IRQ_W{1'b0}};
		end else begin
			if (ENG_COND_VALID_IN) begin
				cond_code_q <= ENG_COND_CODE_IN; // [RULE4]
			end
			hit_q <= hit_d;
			irq_flag_q <= irq_flag_d;
			irq_status_q <= irq_status_d;
		end
	end

	// Slave addressing outcome for the bus engine
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			addressed_q <= 1'b0;
			gcall_q <= 1'b0;
		end else if (ENG_START_STOP_IN || master_q) begin
			addressed_q <= 1'b0; // [RULE8]
			gcall_q <= 1'b0;
		end else if (ENG_ADDR_VALID_IN) begin
			addressed_q <= ack_assert_q && slot_hit[0]; // [RULE5]
			gcall_q <= ack_assert_q && is_gcall && slave_id_primary_q[`I2CSAD_GC_BIT]; // [RULE7]
		end
	end

	// Register read path, one cycle latency
	always @(posedge CLK_IN) begin
		if (RESET_IN) begin
			REG_RDATA_OUT <= 32'h00000000;
		end else if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				`I2CSAD_OFF_BYTE_BUFFER: REG_RDATA_OUT <= {24'h000000, byte_buffer_q}; // [RULE1]
				`I2CSAD_OFF_SLAVE_ID_PRIMARY: REG_RDATA_OUT <= {24'h000000, slave_id_primary_q};
				`I2CSAD_OFF_COND_CODE: REG_RDATA_OUT <= {24'h000000, cond_code_q}; // [RULE4]
				`I2CSAD_OFF_SLAVE_ID_SECOND: REG_RDATA_OUT <= {24'h000000, slave_id_second_q, 1'b0}; // [RULE13]
				`I2CSAD_OFF_SLAVE_ID_THIRD: REG_RDATA_OUT <= {24'h000000, slave_id_third_q, 1'b0}; // [RULE13]
				`I2CSAD_OFF_HIT_FLAGS: REG_RDATA_OUT <= {29'h00000000, hit_q}; // [RULE9]
				`I2CSAD_OFF_CONTROL: REG_RDATA_OUT <= {29'h00000000, master_q, irq_flag_q, ack_assert_q};
				`I2CSAD_OFF_IRQ_STATUS: REG_RDATA_OUT <= {29'h00000000, irq_status_q};
				`I2CSAD_OFF_IRQ_MASK: REG_RDATA_OUT <= {29'h00000000, irq_mask_q};
				default: REG_RDATA_OUT <= 32'h00000000; // [RULE13]
			endcase
		end else begin
			REG_RDATA_OUT <= 32'h00000000;
		end
	end

	// Outputs to the bus engine
	assign ENG_TX_BYTE_OUT = byte_buffer_q; // [RULE1]
	assign ENG_ACK_ASSERT_OUT = ack_assert_q;
	assign ENG_ACK_BIT_OUT = ~ack_assert_q; // [RULE12]
	assign ENG_ADDRESSED_OUT = addressed_q;
	assign ENG_GCALL_OUT = gcall_q;
	assign ENG_HOLD_SCL_OUT = irq_flag_q;
	assign ENG_MASTER_OUT = master_q;

	// Level interrupt from unmasked sticky bits
	assign IRQ_OUT = |(irq_status_q & irq_mask_q);
endmodule

// ===== verif/i2csad_regs_assertions.sv
`timescale 1ns/100ps
module i2csad_checker (
	// Clock and reset
	input wire CLK_IN,
	input wire RESET_IN,
	// Engine side
	input wire ENG_COND_VALID_IN,
	input wire [7:0] ENG_COND_CODE_IN,
	input wire ENG_RX_BYTE_VALID_IN,
	input wire [7:0] ENG_RX_BYTE_IN,
	input wire ENG_ADDR_VALID_IN,
	input wire [7:0] ENG_TX_BYTE_OUT,
	input wire ENG_ACK_ASSERT_OUT,
	input wire ENG_ACK_BIT_OUT,
	input wire ENG_ADDRESSED_OUT,
	input wire ENG_GCALL_OUT,
	input wire ENG_HOLD_SCL_OUT,
	input wire ENG_MASTER_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	// Data byte, flag and addressing relations
	a_rx_byte_kept: assert property (ENG_RX_BYTE_VALID_IN |=> ENG_TX_BYTE_OUT == $past(ENG_RX_BYTE_IN))
		else $error("rx byte");
	a_idle_flag_low: assert property (ENG_COND_VALID_IN && ENG_COND_CODE_IN == 8'hF8 |=> !ENG_HOLD_SCL_OUT)
		else $error("idle flag");
	a_cond_flag_set: assert property (ENG_COND_VALID_IN && ENG_COND_CODE_IN != 8'hF8 |=> ENG_HOLD_SCL_OUT)
		else $error("cond flag");
	a_addr_need_ack: assert property ($rose(ENG_ADDRESSED_OUT) |-> $past(ENG_ADDR_VALID_IN && ENG_ACK_ASSERT_OUT))
		else $error("addressed");
	a_no_ack_ignore: assert property (ENG_ADDR_VALID_IN && !ENG_ACK_ASSERT_OUT
		|=> !ENG_ADDRESSED_OUT && !ENG_GCALL_OUT) else $error("no ack");
	a_gcall_need_ack: assert property ($rose(ENG_GCALL_OUT) |-> $past(ENG_ADDR_VALID_IN && ENG_ACK_ASSERT_OUT))
		else $error("gcall");
	a_master_ignore: assert property (ENG_ADDR_VALID_IN && ENG_MASTER_OUT
		|=> !ENG_ADDRESSED_OUT && !ENG_GCALL_OUT) else $error("master");
	a_ack_bit_level: assert property (ENG_ACK_BIT_OUT == !ENG_ACK_ASSERT_OUT)
		else $error("ack bit");
endmodule

bind i2csad_regs i2csad_checker chk_u (.*);

// ===== verif/i2csad_bus_model.sv
`timescale 1ns/100ps
// Engine stand-in; the byte line shows inverted data between events
module i2csad_bus_model (
	input wire clk,
	output logic [3:0] vld,
	output logic [7:0] byt
);
	initial {vld, byt} = 12'h0;
	// Event k: 0 condition, 1 data, 2 address, 3 START or STOP
	task ev(input int k, input logic [7:0] b);
		@(posedge clk);
		vld <= 4'h1 << k;
		byt <= b;
		@(posedge clk);
		vld <= 4'h0;
		byt <= ~b;
		@(negedge clk);
	endtask
endmodule

// ===== verif/i2c_slave_addr_data_regs_bench.sv
`timescale 1ns/100ps
module i2c_slave_addr_data_regs_bench;
	logic clk = 0, rst = 1, wr = 0, rd = 0, ack, ackb, adrd, gc, hold, mst, irq;
	logic [7:0] ra = 8'h00, byt, txb;
	logic [31:0] wd = 32'h0, rdat;
	logic [3:0] vld;
	int fails = 0, n_checks = 0, cyc = 0;
	logic [7:0] offs [7] = '{8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h2C};
	logic [7:0] ids [4] = '{8'h52, 8'h20, 8'hFE, 8'h45};
	i2csad_bus_model eng (.clk(clk), .vld(vld), .byt(byt));
	i2csad_regs dut (.CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(ra), .REG_WDATA_IN(wd), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .ENG_COND_VALID_IN(vld[0]), .ENG_COND_CODE_IN(byt),
		.ENG_RX_BYTE_VALID_IN(vld[1]), .ENG_RX_BYTE_IN(byt), .ENG_ADDR_VALID_IN(vld[2]), .ENG_ADDR_BYTE_IN(byt),
		.ENG_START_STOP_IN(vld[3]), .ENG_TX_BYTE_OUT(txb), .ENG_ACK_ASSERT_OUT(ack), .ENG_ACK_BIT_OUT(ackb),
		.ENG_ADDRESSED_OUT(adrd), .ENG_GCALL_OUT(gc), .ENG_HOLD_SCL_OUT(hold), .ENG_MASTER_OUT(mst), .IRQ_OUT(irq));
	initial forever #50 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails = fails + 1;
			give_verdict;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1;
		ra <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
		@(negedge clk);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1;
		ra <= a;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		chk(rdat, exp);
	endtask
	task give_verdict;
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		wr_reg(8'h14, '1);
		foreach (offs[i]) rd_chk(offs[i], offs[i] == 8'h14 ? 32'hF8 : 32'h0);
		wr_reg(8'h0C, 32'hFFFFFF5A);
		chk(32'(txb), 32'h5A);
		eng.ev(1, 8'hC3);
		rd_chk(8'h0C, 32'hC3);
		$display("register test done");
		// Identifier hits with ack on, then ack off, and every interrupt unmasked
		wr_reg(8'h10, 32'h21);
		wr_reg(8'h20, 32'hFF);
		wr_reg(8'h24, 32'h45);
		rd_chk(8'h20, 32'hFE);
		wr_reg(8'h30, 32'h1);
		wr_reg(8'h38, 32'h7);
		foreach (ids[i]) begin
			eng.ev(2, ids[i]);
			rd_chk(8'h28, i ? 32'h1 << (i - 1) : 32'h0);
		end
		eng.ev(3, 8'h00);
		rd_chk(8'h28, 32'h0);
		wr_reg(8'h34, 32'h7);
		eng.ev(2, 8'h00);
		chk(32'({irq, gc}), 32'h3);
		rd_chk(8'h34, 32'h4);
		eng.ev(2, 8'h20);
		chk(32'({ack, ackb, adrd, gc}), 32'hA);
		wr_reg(8'h30, 32'h0);
		eng.ev(2, 8'h20);
		chk(32'({ack, ackb, adrd}), 32'h2);
		eng.ev(2, 8'h00);
		chk(32'(gc), 32'h0);
		$display("address test done");
		// Condition codes, flag cleared by zero, masking
		wr_reg(8'h34, 32'h7);
		eng.ev(0, 8'h60);
		chk(32'({irq, hold}), 32'h3);
		wr_reg(8'h30, 32'h0);
		wr_reg(8'h34, 32'h7);
		chk(32'({irq, hold}), 32'h0);
		wr_reg(8'h38, 32'h0);
		eng.ev(0, 8'h08);
		chk(32'({irq, hold}), 32'h1);
		rd_chk(8'h14, 32'h08);
		eng.ev(0, 8'hF8);
		chk(32'(hold), 32'h0);
		wr_reg(8'h30, 32'h5);
		chk(32'(mst), 32'h1);
		eng.ev(2, 8'h20);
		rd_chk(8'h28, 32'h0);
		$display("condition test done");
		give_verdict;
	end
endmodule
